// File: rtl/sse_defs.svh
// Constant definitions for the safety start element
`ifndef SSE_DEFS_SVH
`define SSE_DEFS_SVH

// ------------------------------------------------------------
// Diagnostic codes
// ------------------------------------------------------------
`define SSE_DG_NO_ENABLE    16'h0000
`define SSE_DG_WAIT_COND    16'h2001
`define SSE_DG_WAIT_RISE    16'h2003
`define SSE_DG_WAIT_FALL    16'h2004
`define SSE_DG_PERMIT       16'h8008
`define SSE_DG_STARTUP_ERR  16'hf00b

// ------------------------------------------------------------
// Register map (word index times four)
// ------------------------------------------------------------
`define SSE_ADDR_CTRL       8'h00
`define SSE_ADDR_STATUS     8'h04
`define SSE_ADDR_IRQ_STAT   8'h08
`define SSE_ADDR_IRQ_MASK   8'h0c
`define SSE_ADDR_DIAG       8'h10

// ------------------------------------------------------------
// Control field positions and reset values
// ------------------------------------------------------------
`define SSE_CTRL_EXT_EN_BIT 0
`define SSE_CTRL_MODE_BIT   1
`define SSE_CTRL_RESET      2'h0

// ------------------------------------------------------------
// Interrupt event bit positions
// ------------------------------------------------------------
`define SSE_EV_PERMIT_ON    0
`define SSE_EV_PERMIT_OFF   1
`define SSE_EV_FAULT        2
`define SSE_EV_WIDTH        3

`endif

// File: rtl/sse_pkg.sv
// Type package for the safety start element
package sse_pkg;

  // Main sequencer states
  typedef enum logic [2:0]
  {
    SSE_ST_OFF   = 3'b000,
    SSE_ST_ENTRY = 3'b001,
    SSE_ST_WAIT  = 3'b010,
    SSE_ST_ARMED = 3'b011,
    SSE_ST_RUN   = 3'b100,
    SSE_ST_FAULT = 3'b101
  } sse_state_t;

  // Start mode selection
  typedef enum logic
  {
    SSE_MODE_MANUAL     = 1'b0,
    SSE_MODE_CONTROLLED = 1'b1
  } sse_mode_t;

endpackage

// File: rtl/sse_start_element.sv
// Safety start element with register port and interrupt
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "sse_defs.svh"

module sse_start_element
  import sse_pkg::*;
(
  input  wire logic        i_sys_clk,                // System clock, 125 MHz
  input  wire logic        i_rstn,                   // Asynchronous reset, active low
  input  wire logic        i_start_condition_input,  // Start condition pin
  input  wire logic        i_start_trigger_input,    // Start trigger (reset button) pin
  input  wire logic        i_block_enable_input,     // External block enable pin
  input  wire logic [7:0]  i_addr,                   // Register byte address
  input  wire logic [31:0] i_wdata,                  // Register write data
  input  wire logic        i_wr,                     // Write strobe
  input  wire logic        i_rd,                     // Read strobe
  output logic      [31:0] o_rdata,                  // Read data, cycle after strobe
  output logic             o_start_permit_output,    // Start permit
  output logic             o_fault_flag_output,      // Fault flag
  output logic      [31:0] o_diagnostic_output,      // Diagnostic double word
  output logic             o_irq                     // Level interrupt
);

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  logic [2:0] sync_a;      // First stage, read only by second
  logic [2:0] sync_b;      // Second stage, usable level
  logic       trig_q;      // Previous trigger level for edge detect

  // Pins are asynchronous to the system clock, so two stages each
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
    end
    else
    begin
      sync_a <= {i_block_enable_input, i_start_trigger_input, i_start_condition_input};
      sync_b <= sync_a;
    end
  end

  wire cond_s = sync_b[0];   // Synchronised start condition
  wire trig_s = sync_b[1];   // Synchronised start trigger
  wire en_pin = sync_b[2];   // Synchronised external enable

  // Trigger history for edge detection
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      trig_q <= 1'b0;
    else
      trig_q <= trig_s;
  end

  // ------------------------------------------------------------
  // Start-up settle
  // ------------------------------------------------------------
  logic [1:0] settle;      // Fills with ones while the synchronisers load

  // The startup check must judge real pin levels, not the cleared stages,
  // so the block stays off until both synchroniser stages hold pin values
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      settle <= '0;
    else
      settle <= {settle[0], 1'h1};
  end

  wire pins_ok = settle[1]; // Both synchroniser stages carry pin levels

  // ------------------------------------------------------------
  // Control register
  // ------------------------------------------------------------
  logic [1:0] ctrl;        // Bit0 external enable required, bit1 mode

  wire       wr_ctrl  = i_wr && (i_addr == `SSE_ADDR_CTRL);
  wire       wr_mask  = i_wr && (i_addr == `SSE_ADDR_IRQ_MASK);
  wire       rd_stat  = i_rd && (i_addr == `SSE_ADDR_IRQ_STAT);
  wire       ext_req  = ctrl[`SSE_CTRL_EXT_EN_BIT];
  wire       mode_bit = ctrl[`SSE_CTRL_MODE_BIT];
  wire       mode_ctl = (sse_mode_t'(mode_bit) == SSE_MODE_CONTROLLED);

  // Reset value selects no external enable and manual start
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      ctrl <= `SSE_CTRL_RESET;
    else if (wr_ctrl)
      ctrl <= i_wdata[1:0];
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  sse_state_t state;       // Current state
  sse_state_t next_state;  // Next state

  // Without the external enable setting the block is always active
  // Held off after reset until the pin pipeline is filled
  wire active    = pins_ok && (!ext_req || en_pin);
  wire rise      = trig_s && !trig_q;
  wire fall      = !trig_s && trig_q;
  wire start_cmd = mode_ctl ? fall : rise;

  // Next state decode
  always_comb
  begin
    next_state = state;
    case (state)
      SSE_ST_OFF:
      begin
        if (active)
          next_state = SSE_ST_ENTRY;
      end
      SSE_ST_ENTRY:
      begin
        // Inputs already closed when enabled block an automatic start
        if (cond_s && trig_s)
          next_state = SSE_ST_FAULT;
        else if (cond_s)
          next_state = SSE_ST_ARMED;
        else
          next_state = SSE_ST_WAIT;
      end
      SSE_ST_WAIT:
      begin
        // Edges seen here are discarded: condition not yet present
        if (cond_s)
          next_state = SSE_ST_ARMED;
      end
      SSE_ST_ARMED:
      begin
        if (!cond_s)
          next_state = SSE_ST_WAIT;
        else if (start_cmd)
          next_state = SSE_ST_RUN;
      end
      SSE_ST_RUN:
      begin
        if (!cond_s)
          next_state = SSE_ST_WAIT;
      end
      SSE_ST_FAULT:
      begin
        if (!cond_s && !trig_s)
          next_state = SSE_ST_WAIT;
      end
      default:
        next_state = SSE_ST_OFF;
    endcase
    // Dropping the enable overrides everything
    if (!active)
      next_state = SSE_ST_OFF;
  end

  // State register
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      state <= SSE_ST_OFF;
    else
      state <= next_state;
  end

  // ------------------------------------------------------------
  // Outputs derived from the next state, registered
  // ------------------------------------------------------------
  logic [15:0] next_diag;  // Diagnostic code for next state
  wire         next_permit = (next_state == SSE_ST_RUN);
  wire         next_fault  = (next_state == SSE_ST_FAULT);

  // Diagnostic code selection
  always_comb
  begin
    case (next_state)
      SSE_ST_OFF:   next_diag = `SSE_DG_NO_ENABLE;
      SSE_ST_ENTRY: next_diag = `SSE_DG_WAIT_COND;
      SSE_ST_WAIT:  next_diag = `SSE_DG_WAIT_COND;
      SSE_ST_ARMED: next_diag = mode_ctl ? `SSE_DG_WAIT_FALL : `SSE_DG_WAIT_RISE;
      SSE_ST_RUN:   next_diag = `SSE_DG_PERMIT;
      SSE_ST_FAULT: next_diag = `SSE_DG_STARTUP_ERR;
      default:      next_diag = `SSE_DG_NO_ENABLE;
    endcase
  end

  // Output flops keep outputs glitch free
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_start_permit_output <= 1'b0;
      o_fault_flag_output   <= 1'b0;
      o_diagnostic_output   <= 32'h0;
    end
    else
    begin
      o_start_permit_output <= next_permit;
      o_fault_flag_output   <= next_fault;
      o_diagnostic_output   <= {16'h0, next_diag};
    end
  end

  // ------------------------------------------------------------
  // Interrupt status and mask
  // ------------------------------------------------------------
  logic [`SSE_EV_WIDTH-1:0] irq_stat;  // Sticky event bits
  logic [`SSE_EV_WIDTH-1:0] irq_mask;  // Enable per event
  wire  [`SSE_EV_WIDTH-1:0] events;    // One-cycle event pulses

  assign events[`SSE_EV_PERMIT_ON]  = next_permit && !o_start_permit_output;
  assign events[`SSE_EV_PERMIT_OFF] = !next_permit && o_start_permit_output;
  assign events[`SSE_EV_FAULT]      = next_fault && !o_fault_flag_output;

  // Per-bit sticky status; a new event wins over the read clear
  genvar gi;
  generate
    for (gi = 0; gi < `SSE_EV_WIDTH; gi = gi + 1)
    begin : g_irq
      always_ff @(posedge i_sys_clk or negedge i_rstn)
      begin
        if (!i_rstn)
          irq_stat[gi] <= 1'b0;
        else if (events[gi])
          irq_stat[gi] <= 1'b1;
        else if (rd_stat)
          irq_stat[gi] <= 1'b0;
      end
    end
  endgenerate

  // Mask register
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      irq_mask <= '0;
    else if (wr_mask)
      irq_mask <= i_wdata[`SSE_EV_WIDTH-1:0];
  end

  // Interrupt level registered from the next status
  wire [`SSE_EV_WIDTH-1:0] next_stat = events | (rd_stat ? '0 : irq_stat);

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_irq <= 1'b0;
    else
      o_irq <= |(next_stat & irq_mask);
  end

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  logic [31:0] rd_mux;     // Selected read word

  // Unmapped addresses read zero
  always_comb
  begin
    case (i_addr)
      `SSE_ADDR_CTRL:     rd_mux = {30'h0, ctrl};
      `SSE_ADDR_STATUS:   rd_mux = {23'h0, state, active, o_fault_flag_output,
                                    o_start_permit_output, trig_s, cond_s, en_pin};
      `SSE_ADDR_IRQ_STAT: rd_mux = {29'h0, irq_stat};
      `SSE_ADDR_IRQ_MASK: rd_mux = {29'h0, irq_mask};
      `SSE_ADDR_DIAG:     rd_mux = o_diagnostic_output;
      default:            rd_mux = 32'h0;
    endcase
  end

  // Read data valid the cycle after the strobe only
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_rdata <= 32'h0;
    else if (i_rd)
      o_rdata <= rd_mux;
    else
      o_rdata <= 32'h0;
  end

endmodule

// File: test/sse_start_element_properties.sv
// Port-level checker for the safety start element
`timescale 1ns/1ps
module sse_properties
(
  input wire logic        i_sys_clk,               // System clock
  input wire logic        i_rstn,                  // Reset, active low
  input wire logic        i_start_condition_input, // Condition pin
  input wire logic        i_start_trigger_input,   // Trigger pin
  input wire logic        o_start_permit_output,   // Permit
  input wire logic        o_fault_flag_output,     // Fault flag
  input wire logic [31:0] o_diagnostic_output      // Diagnostic word
);
  // ----------------------------------------------------------
  // Properties
  // ----------------------------------------------------------
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rstn);
  // Short aliases; pins reach the state three edges late
  wire        cnd = i_start_condition_input;
  wire        trg = i_start_trigger_input;
  wire        prm = o_start_permit_output;
  wire        flt = o_fault_flag_output;
  wire [31:0] dg  = o_diagnostic_output;
  a_diag_legal: assert property (
    dg inside {32'h0, 32'h2001, 32'h2003, 32'h2004, 32'h8008, 32'hf00b})
    else $error("diag word outside the code set");
  a_permit_code: assert property (prm |-> dg == 32'h8008)
    else $error("permit without code 8008");
  a_fault_code: assert property (flt |-> dg == 32'hf00b)
    else $error("fault without code f00b");
  a_fault_blocks: assert property (flt |-> !prm)
    else $error("permit during fault");
  a_permit_drop: assert property ((!cnd) [*3] |=> !prm)
    else $error("permit held without condition");
  a_permit_cond: assert property ($rose(prm) |-> $past(cnd, 3))
    else $error("permit rose without condition");
  a_permit_edge: assert property (
    $rose(prm) |-> $past(trg, 3) != $past(trg, 4))
    else $error("permit rose without trigger edge");
  a_fault_clear: assert property ((!cnd && !trg) [*3] |=> !flt)
    else $error("fault kept after release");
  a_off_idle: assert property (dg == 32'h0 |-> !prm && !flt)
    else $error("outputs active while disabled");
endmodule

// File: test/sse_pins.sv
// Behavioural model of the pins wired to the start element
`timescale 1ns/1ps
module sse_pins
(
  input  wire logic i_sys_clk, // Pin changes align to this clock
  output logic      o_cond,    // Start condition level
  output logic      o_trig,    // Start trigger button
  output logic      o_en       // External enable level
);
  // ----------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------
  // Idle: every pin released
  initial
  begin
    o_cond = 1'b0;
    o_trig = 1'b0;
    o_en   = 1'b0;
  end
  task set_cond(input logic v);
    @(posedge i_sys_clk);
    o_cond <= v;
  endtask
  task set_trig(input logic v);
    @(posedge i_sys_clk);
    o_trig <= v;
  endtask
  task set_en(input logic v);
    @(posedge i_sys_clk);
    o_en <= v;
  endtask
  // Fault acknowledge: both pins dropped together
  task release_all;
    @(posedge i_sys_clk);
    o_cond <= 1'b0;
    o_trig <= 1'b0;
  endtask
endmodule

// File: test/sse_start_element_test.sv
// Self-checking bench for the safety start element
`timescale 1ns/1ps
`include "sse_defs.svh"
module sse_start_element_test;
  // ----------------------------------------------------------
  // Signals, model and design
  // ----------------------------------------------------------
  logic        i_sys_clk, i_rstn, i_wr, i_rd, cond, trig, en;
  logic [7:0]  i_addr;
  logic [31:0] i_wdata, o_rdata, o_diagnostic_output, rv;
  logic        o_start_permit_output, o_fault_flag_output, o_irq;
  int          num_errors, n_compared;
  sse_pins pins (.i_sys_clk(i_sys_clk), .o_cond(cond), .o_trig(trig), .o_en(en));
  sse_start_element dut (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
    .i_start_condition_input(cond), .i_start_trigger_input(trig),
    .i_block_enable_input(en), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_start_permit_output(o_start_permit_output),
    .o_fault_flag_output(o_fault_flag_output),
    .o_diagnostic_output(o_diagnostic_output), .o_irq(o_irq));
  initial
  begin
    i_sys_clk = 1'b0;
    forever #4 i_sys_clk = ~i_sys_clk;
  end
  // ----------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------
  task chk(input string nm, input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Five edges cover the three-edge pin latency plus entry
  task step(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 rv = o_rdata;
  endtask
  task outs(input logic p, f, input logic [31:0] d);
    step(5);
    chk("permit", {31'h0, o_start_permit_output}, {31'h0, p});
    chk("fault", {31'h0, o_fault_flag_output}, {31'h0, f});
    chk("diag", o_diagnostic_output, d);
  endtask
  task report_and_stop;
    if (num_errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task t_manual;
    wr(`SSE_ADDR_IRQ_MASK, 32'h1);
    pins.set_cond(1'b1);
    outs(1'b0, 1'b0, 32'h2003);
    pins.set_trig(1'b1);
    outs(1'b1, 1'b0, 32'h8008);
    chk("irq", {31'h0, o_irq}, 32'h1);
    rd(`SSE_ADDR_IRQ_STAT);
    chk("irq stat", rv, 32'h1);
    step(2);
    chk("irq", {31'h0, o_irq}, 32'h0);
    pins.set_trig(1'b0);
    pins.set_cond(1'b0);
    outs(1'b0, 1'b0, 32'h2001);
  endtask
  task t_controlled;
    wr(`SSE_ADDR_CTRL, 32'h2);
    pins.set_trig(1'b1);
    pins.set_trig(1'b0);
    outs(1'b0, 1'b0, 32'h2001);
    pins.set_cond(1'b1);
    outs(1'b0, 1'b0, 32'h2004);
    pins.set_trig(1'b1);
    outs(1'b0, 1'b0, 32'h2004);
    pins.set_trig(1'b0);
    outs(1'b1, 1'b0, 32'h8008);
    pins.set_cond(1'b0);
    outs(1'b0, 1'b0, 32'h2001);
    rd(`SSE_ADDR_IRQ_STAT);
    chk("irq stat", rv, 32'h3);
  endtask
  task t_fault;
    wr(`SSE_ADDR_CTRL, 32'h1);
    outs(1'b0, 1'b0, 32'h0);
    pins.set_cond(1'b1);
    pins.set_trig(1'b1);
    outs(1'b0, 1'b0, 32'h0);
    pins.set_en(1'b1);
    outs(1'b0, 1'b1, 32'hf00b);
    chk("irq masked", {31'h0, o_irq}, 32'h0);
    rd(`SSE_ADDR_IRQ_STAT);
    chk("irq stat", rv, 32'h4);
    rd(`SSE_ADDR_STATUS);
    chk("status", rv, 32'h177);
    rd(`SSE_ADDR_DIAG);
    chk("diag reg", rv, 32'hf00b);
    pins.release_all;
    outs(1'b0, 1'b0, 32'h2001);
    rd(8'h14);
    chk("unmapped", rv, 32'h0);
  endtask
  // Both pins closed across a reset must still trip the startup check
  task t_reset_fault;
    @(posedge i_sys_clk);
    i_rstn <= 1'b0;
    pins.set_cond(1'b1);
    pins.set_trig(1'b1);
    @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    outs(1'b0, 1'b1, 32'hf00b);
    pins.release_all;
    outs(1'b0, 1'b0, 32'h2001);
  endtask
  // ----------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------
  initial
  begin
    num_errors = 0;
    n_compared = 0;
    i_rstn = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 8'h0;
    i_wdata = 32'h0;
    repeat (2) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    outs(1'b0, 1'b0, 32'h2001);
    rd(`SSE_ADDR_CTRL);
    chk("ctrl", rv, 32'h0);
    t_manual;
    t_controlled;
    t_fault;
    t_reset_fault;
    report_and_stop;
  end
  initial
  begin
    #100us;
    num_errors++;
    report_and_stop;
  end
endmodule
bind sse_start_element sse_properties u_props (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
  .i_start_condition_input(i_start_condition_input),
  .i_start_trigger_input(i_start_trigger_input),
  .o_start_permit_output(o_start_permit_output),
  .o_fault_flag_output(o_fault_flag_output),
  .o_diagnostic_output(o_diagnostic_output));
